// ===== dv/core_ack_model.sv
// core model: raises int_ack on the edge ack_dly cycles after the edge where it first sees int_req high
// assumes int_req is a registered level
`timescale 1ns/1ps
`default_nettype none
module core_ack_model (
  // clock and reset
  input wire clk,
  input wire reset,
  // dispatch handshake
  input wire int_req,
  input wire [3:0] ack_dly,
  output logic int_ack = 1'h0
);
  logic [3:0] cnt_q = 4'h0;
  // one-cycle accept; a long wait mimics a core busy elsewhere
  always @(posedge clk) begin
    if (reset || int_ack || !int_req) begin
      cnt_q <= 4'h0;
      int_ack <= 1'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      int_ack <= (cnt_q == ack_dly);
    end
  end
endmodule
`default_nettype wire

// ===== dv/prio_int_ctrl_checker.sv
// assertions on the interrupt control block's ports
// bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module prio_int_ctrl_checker (
  // clock and reset
  input wire clk,
  input wire reset,
  // register read side
  input wire [1:0] addr,
  input wire rd_stb,
  input wire [7:0] rdata,
  input wire rx_buffer_full,
  input wire tx_buffer_empty,
  // dispatch and pull-ups
  input wire priority_mode_enable,
  input wire int_ack,
  input wire int_req,
  input wire [15:0] int_vector,
  input wire [3:0] port_b_latch,
  input wire [3:0] pullup_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // mirrors lag their inputs by one cycle, so the read sees two back
  a_edges_reserved: assert property (rd_stb && addr == 2'h1 |=>
    (rdata & 8'h0a) == 8'h00) else $error("edges reserved bit set");
  a_ext_reserved: assert property (rd_stb && addr == 2'h2 |=>
    (rdata & 8'h24) == 8'h00) else $error("ext reserved bit set");
  a_rx_mirror: assert property (rd_stb && addr == 2'h3 |=>
    rdata[5] == $past(rx_buffer_full, 2)) else $error("rx flag wrong");
  a_tx_mirror: assert property (rd_stb && addr == 2'h3 |=>
    rdata[4] == $past(tx_buffer_empty, 2)) else $error("tx flag wrong");
  a_compat_vector: assert property (int_req && !priority_mode_enable &&
    !$past(priority_mode_enable) |-> int_vector == 16'h0008)
    else $error("compat vector wrong");
  a_vector_legal: assert property (int_req |-> int_vector == 16'h0008 ||
    int_vector == 16'h0018) else $error("vector illegal");
  a_ack_drops: assert property (int_ack && int_req |=> !int_req)
    else $error("request held after accept");
  a_pullup_follow: assert property (pullup_en == 4'h0 ||
    pullup_en == $past(port_b_latch)) else $error("pull-up wrong");
endmodule
bind prio_int_ctrl prio_int_ctrl_checker chk_i (.clk(clk), .reset(reset),
  .addr(addr), .rd_stb(rd_stb), .rdata(rdata),
  .rx_buffer_full(rx_buffer_full), .tx_buffer_empty(tx_buffer_empty),
  .priority_mode_enable(priority_mode_enable), .int_ack(int_ack),
  .int_req(int_req), .int_vector(int_vector),
  .port_b_latch(port_b_latch), .pullup_en(pullup_en));
`default_nettype wire

// ===== dv/prio_int_ctrl_test.sv
// bench for the prioritized interrupt control block
// assumes core_ack_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module prio_int_ctrl_test;
  logic clk = 1'h0, reset = 1'h1, wr_stb = 1'h0, rd_stb = 1'h0;
  logic rd_d = 1'h0, pm = 1'h0, pb_rd = 1'h0, rx = 1'h0, tx = 1'h1;
  logic req, ack;
  logic [1:0] addr = 2'h0;
  logic [2:0] pin = 3'h0;
  logic [3:0] pb = 4'h0, latch = 4'h0, dly = 4'h0, pull;
  logic [7:0] wdata = 8'h00, pen = 8'h00, pprio = 8'h00, rdata;
  logic [8:0] ev = 9'h000;
  logic [15:0] vec;
  logic [7:0] rd_exp [$];
  logic [15:0] vec_exp [$];
  logic [31:0] rng = 32'h00009885;
  int err_count = 0, compares = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  // ev[8] is the timer-0 overflow pulse
  prio_int_ctrl uut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .priority_mode_enable(pm), .timer0_ovf(ev[8]), .ext_pin0(pin[0]),
    .ext_pin1(pin[1]), .ext_pin2(pin[2]), .port_b_upper_pins(pb),
    .port_b_read(pb_rd), .port_b_latch(latch),
    .parallel_port_access(ev[7]), .converter_done(ev[6]),
    .rx_buffer_full(rx), .tx_buffer_empty(tx), .sync_serial_done(ev[3]),
    .capcomp1_event(ev[2]), .timer2_match(ev[1]), .timer1_ovf(ev[0]),
    .periph_enable(pen), .periph_prio(pprio), .int_ack(ack),
    .int_req(req), .int_vector(vec), .pullup_en(pull));
  core_ack_model core (.clk(clk), .reset(reset), .int_req(req),
    .ack_dly(dly), .int_ack(ack));
  // xorshift step for random stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'h1;
    rd_exp.push_back(e);
    @(posedge clk);
    rd_stb <= 1'h0;
  endtask
  // one-cycle events, then time for the flag to land
  task pulse(input logic [8:0] p);
    @(posedge clk);
    ev <= p;
    @(posedge clk);
    ev <= 9'h000;
    repeat (2) @(posedge clk);
  endtask
  task print_verdict;
    $display("compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // scoreboard: oldest note against each read answer and accept
  always @(posedge clk) begin
    rd_d <= rd_stb;
    if (rd_d)
      chk({8'h00, rdata}, {8'h00, rd_exp.pop_front()});
    if (ack && req)
      chk(vec, vec_exp.pop_front());
  end
  // hang guard, far past the expected run length
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'hf5);
    rd(2'h2, 8'hc0);
    rd(2'h3, 8'h10);
    rng = xs(rng);
    wr(2'h1, rng[7:0]);
    rd(2'h1, rng[7:0] & 8'hf5);
    wr(2'h2, 8'hff);
    rd(2'h2, 8'hdb);
    wr(2'h2, 8'h00);
    wr(2'h1, 8'h75);
    latch <= rng[11:8];
    $display("registers done");
    // every flag but port change and transmit, all enables off
    rx <= 1'h1;
    tx <= 1'h0;
    pin <= 3'h7;
    pulse(9'h1cf);
    rd(2'h0, 8'h06);
    rd(2'h2, 8'h03);
    rd(2'h3, 8'hef);
    chk({12'h000, pull}, {12'h000, rng[11:8]});
    wr(2'h1, 8'h05);
    wr(2'h0, 8'h00);
    pin <= 3'h0;
    repeat (3) @(posedge clk);
    rd(2'h0, 8'h02);
    // clear and converter event in the same cycle
    @(posedge clk);
    addr <= 2'h3;
    wdata <= 8'h00;
    wr_stb <= 1'h1;
    ev <= 9'h040;
    @(posedge clk);
    wr_stb <= 1'h0;
    ev <= 9'h000;
    rd(2'h3, 8'h60);
    wr(2'h0, 8'h00);
    pb <= rng[15:12] | 4'h1;
    repeat (3) @(posedge clk);
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h01);
    @(posedge clk);
    pb_rd <= 1'h1;
    @(posedge clk);
    pb_rd <= 1'h0;
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h00);
    $display("flags done");
    // single-vector dispatch, prompt then slow core
    wr(2'h3, 8'h00);
    wr(2'h0, 8'ha0);
    vec_exp.push_back(16'h0008);
    pulse(9'h100);
    repeat (4) @(posedge clk);
    rd(2'h0, 8'h24);
    pen <= 8'h40;
    wr(2'h0, 8'h80);
    pulse(9'h040);
    chk({15'h0000, req}, 16'h0000);
    dly <= 4'h5;
    vec_exp.push_back(16'h0008);
    wr(2'h0, 8'hc0);
    repeat (10) @(posedge clk);
    rd(2'h0, 8'h40);
    wr(2'h3, 8'h00);
    // priority mode, low then high source
    pm <= 1'h1;
    wr(2'h1, 8'h71);
    wr(2'h0, 8'he0);
    vec_exp.push_back(16'h0018);
    pulse(9'h100);
    repeat (8) @(posedge clk);
    rd(2'h0, 8'ha4);
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h75);
    wr(2'h0, 8'ha0);
    vec_exp.push_back(16'h0008);
    pulse(9'h100);
    repeat (8) @(posedge clk);
    rd(2'h0, 8'h24);
    // high-priority peripheral needs no low enable
    pprio <= 8'h40;
    wr(2'h0, 8'h80);
    vec_exp.push_back(16'h0008);
    pulse(9'h040);
    repeat (10) @(posedge clk);
    rd(2'h0, 8'h00);
    repeat (2) @(posedge clk);
    $display("dispatch done");
    print_verdict;
  end
endmodule
`default_nettype wire

// ===== include/int_ctrl_consts.vh
// constants for the prioritized interrupt control block
// assumes 8-bit registers reached by a small address/strobe port
`ifndef INT_CTRL_CONSTS_VH
`define INT_CTRL_CONSTS_VH
// register indices
`define ADDR_MAIN 2'h0
`define ADDR_EDGES 2'h1
`define ADDR_EXT 2'h2
`define ADDR_PFLAGS 2'h3
// reset values
`define RST_MAIN 8'h00
`define RST_EDGES 8'hf5
`define RST_EXT 8'hc0
`define RST_PFLAGS 8'h00
// implemented-bit masks
`define MASK_EDGES 8'hf5
`define MASK_EXT 8'hdb
// main register fields
`define B_GIE 7
`define B_PEIE 6
`define B_T0IE 5
`define B_I0IE 4
`define B_PORT_CHANGE_ENABLE 3
`define B_T0IF 2
`define B_I0IF 1
`define B_PORT_CHANGE_FLAG 0
// edges/priority register fields
`define B_PUDIS 7
`define B_EDG0 6
`define B_EDG1 5
`define B_EDG2 4
`define B_T0IP 2
`define B_PORT_CHANGE_PRIO 0
// external pins register fields
`define B_I2IP 7
`define B_I1IP 6
`define B_I2IE 4
`define B_I1IE 3
`define B_I2IF 1
`define B_I1IF 0
// peripheral flag fields
`define B_PPF 7
`define B_RXF 5
`define B_TXF 4
`define B_ADF 6
`define B_SSF 3
`define B_CCF 2
`define B_T2F 1
`define B_T1F 0
// peripheral flags software may write, and those it may only read
`define MASK_PF_RW 8'hcf
`define MASK_PF_RO 8'h30
// peripheral flags present on the small package
`define MASK_PF_SMALL 8'h7f
// vector addresses
`define VEC_HIGH 16'h0008
`define VEC_LOW 16'h0018
`endif

// ===== rtl/prio_int_ctrl.v
// prioritized interrupt control: main, edge/priority, external-pin and
// first peripheral flag registers, plus dispatch request to the core.
// assumes event inputs are single-cycle pulses synchronous to clk.
//
// Overview of operation
// - flags set regardless of any enables
// - compat mode: bit7 gates all interrupts
// - priority mode: bit7 enables high priority
// - compat mode: bit6 gates peripheral interrupts
// - priority mode: bit6 enables low priority
// - timer0 overflow sets bit2, enable bit5
// - pin0 selected edge sets bit1, enable bit4
// - upper port-B change sets bit0, enable bit3
// - persistent mismatch keeps re-setting port-change flag
// - edge select bits: one rising, zero falling
// - bit7 disables pull-ups, else latch decides
// - timer0, port-change priority bits: one high
// - unimplemented control bits read as zero
// - pin2/pin1 priorities bits7,6; enables bits4,3
// - pin2/pin1 events set bits1,0
// - parallel port flag; absent on small package
// - converter done bit6, sync serial bit3
// - receive flag follows receive buffer full
// - transmit flag follows transmit buffer empty
// - capture/compare flag on capture or match
// - timer2 match bit1, timer1 overflow bit0
// - priority mode off ignores priority bits
// - pending source vectors to high or low
// - acceptance clears governing global enable
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "int_ctrl_consts.vh"

module prio_int_ctrl #(
  parameter HAS_PARALLEL_PORT = 1
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // register port
  input wire [1:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata,
  // priority mode select from reset-control register
  input wire priority_mode_enable,
  // pin and peripheral events
  input wire timer0_ovf,
  input wire ext_pin0,
  input wire ext_pin1,
  input wire ext_pin2,
  input wire [3:0] port_b_upper_pins,
  input wire port_b_read,
  input wire [3:0] port_b_latch,
  input wire parallel_port_access,
  input wire converter_done,
  input wire rx_buffer_full,
  input wire tx_buffer_empty,
  input wire sync_serial_done,
  input wire capcomp1_event,
  input wire timer2_match,
  input wire timer1_ovf,
  // peripheral enables and priorities from the enable/priority registers
  input wire [7:0] periph_enable,
  input wire [7:0] periph_prio,
  // core handshake
  input wire int_ack,
  output reg int_req,
  output reg [15:0] int_vector,
  output reg [3:0] pullup_en
);

  reg [7:0] main_q;
  reg [7:0] main_d;
  reg [7:0] edges_q;
  reg [7:0] ext_q;
  reg [7:0] ext_d;
  reg [7:0] pf_q;
  reg [7:0] pf_d;
  reg [2:0] pin_q;
  reg [3:0] pb_snap_q;
  reg [15:0] vec_d;
  reg req_d;
  wire wr_main;
  wire wr_edges;
  wire wr_ext;
  wire wr_pf;
  wire ev_pin0;
  wire ev_pin1;
  wire ev_pin2;
  wire mismatch;
  wire [7:0] pf_ev;
  wire [7:0] pf_mask;
  wire t0_pend;
  wire i0_pend;
  wire rb_pend;
  wire i1_pend;
  wire i2_pend;
  wire [7:0] pf_pend;
  wire any_hi;
  wire any_lo;
  wire any_compat;
  // shared terms for the next-value logic
  wire accept;
  wire [7:0] main_hw_set;
  wire [7:0] ext_hw_set;
  wire [7:0] pf_wmask;
  wire pf_any;
  wire [7:0] pf_view;
  // per-source routing by priority bit
  wire t0_hi;
  wire t0_lo;
  wire i0_hi;
  wire rb_hi;
  wire rb_lo;
  wire i1_hi;
  wire i1_lo;
  wire i2_hi;
  wire i2_lo;
  wire pf_hi;
  wire pf_lo;
  // named control register fields
  wire global_or_high_enable;
  wire peripheral_or_low_enable;
  wire timer0_ovf_enable;
  wire ext_pin0_enable;
  wire port_change_enable;
  wire timer0_ovf_flag;
  wire ext_pin0_flag;
  wire port_change_flag;
  wire pullup_disable;
  wire ext_pin0_edge_sel;
  wire ext_pin1_edge_sel;
  wire ext_pin2_edge_sel;
  wire timer0_ovf_prio;
  wire port_change_prio;
  wire ext_pin2_prio;
  wire ext_pin1_prio;
  wire ext_pin2_enable;
  wire ext_pin1_enable;
  wire ext_pin2_flag;
  wire ext_pin1_flag;
  // named peripheral flag fields
  wire parallel_port_flag;
  wire converter_done_flag;
  wire serial_rx_flag;
  wire serial_tx_flag;
  wire sync_serial_flag;
  wire capcomp1_flag;
  wire timer2_match_flag;
  wire timer1_ovf_flag;

  // selected-edge detector; edge_sel one means rising
  function edge_hit;
    input prev;
    input cur;
    input edge_sel;
    begin
      edge_hit = edge_sel ? (~prev & cur) : (prev & ~cur);
    end
  endfunction

  // flag update: software value for writable bits, hardware set wins
  function [7:0] flag_upd;
    input [7:0] cur;
    input [7:0] wval;
    input [7:0] wmask;
    input wr;
    input [7:0] hw_set;
    begin
      flag_upd = (wr ? ((cur & ~wmask) | (wval & wmask)) : cur) | hw_set;
    end
  endfunction

  assign wr_main = wr_stb && addr == `ADDR_MAIN;
  assign wr_edges = wr_stb && addr == `ADDR_EDGES;
  assign wr_ext = wr_stb && addr == `ADDR_EXT;
  assign wr_pf = wr_stb && addr == `ADDR_PFLAGS;

  // main register fields
  assign global_or_high_enable = main_q[`B_GIE];
  assign peripheral_or_low_enable = main_q[`B_PEIE];
  assign timer0_ovf_enable = main_q[`B_T0IE];
  assign ext_pin0_enable = main_q[`B_I0IE];
  assign port_change_enable = main_q[`B_PORT_CHANGE_ENABLE];
  assign timer0_ovf_flag = main_q[`B_T0IF];
  assign ext_pin0_flag = main_q[`B_I0IF];
  assign port_change_flag = main_q[`B_PORT_CHANGE_FLAG];
  // edge select, priority and pull-up fields
  assign pullup_disable = edges_q[`B_PUDIS];
  assign ext_pin0_edge_sel = edges_q[`B_EDG0];
  assign ext_pin1_edge_sel = edges_q[`B_EDG1];
  assign ext_pin2_edge_sel = edges_q[`B_EDG2];
  assign timer0_ovf_prio = edges_q[`B_T0IP];
  assign port_change_prio = edges_q[`B_PORT_CHANGE_PRIO];
  // external pin fields
  assign ext_pin2_prio = ext_q[`B_I2IP];
  assign ext_pin1_prio = ext_q[`B_I1IP];
  assign ext_pin2_enable = ext_q[`B_I2IE];
  assign ext_pin1_enable = ext_q[`B_I1IE];
  assign ext_pin2_flag = ext_q[`B_I2IF];
  assign ext_pin1_flag = ext_q[`B_I1IF];

  // peripheral flag fields; parallel port bit absent on small package
  assign parallel_port_flag = pf_q[`B_PPF] & pf_mask[`B_PPF];
  assign converter_done_flag = pf_q[`B_ADF];
  assign serial_rx_flag = pf_q[`B_RXF];
  assign serial_tx_flag = pf_q[`B_TXF];
  assign sync_serial_flag = pf_q[`B_SSF];
  assign capcomp1_flag = pf_q[`B_CCF];
  assign timer2_match_flag = pf_q[`B_T2F];
  assign timer1_ovf_flag = pf_q[`B_T1F];
  // read view, rebuilt from fields so a dropped bit reads zero
  assign pf_view = {parallel_port_flag, converter_done_flag, serial_rx_flag,
                    serial_tx_flag, sync_serial_flag, capcomp1_flag,
                    timer2_match_flag, timer1_ovf_flag};

  // pin edge events, polarity from edge select bits
  assign ev_pin0 = edge_hit(pin_q[0], ext_pin0, ext_pin0_edge_sel);
  assign ev_pin1 = edge_hit(pin_q[1], ext_pin1, ext_pin1_edge_sel);
  assign ev_pin2 = edge_hit(pin_q[2], ext_pin2, ext_pin2_edge_sel);
  // mismatch persists until a port read refreshes the snapshot
  assign mismatch = port_b_upper_pins != pb_snap_q;

  // peripheral flag events; receive/transmit bits are levels
  assign pf_mask = HAS_PARALLEL_PORT ? 8'hff : `MASK_PF_SMALL;
  assign pf_ev = {parallel_port_access, converter_done, 2'h0,
                  sync_serial_done, capcomp1_event, timer2_match,
                  timer1_ovf} & pf_mask;

  // input history for edge and change detection
  always @(posedge clk) begin
    if (reset) begin
      pin_q <= 3'h0;
      pb_snap_q <= 4'h0;
    end else begin
      pin_q <= {ext_pin2, ext_pin1, ext_pin0};
      if (port_b_read) begin
        pb_snap_q <= port_b_upper_pins;
      end
    end
  end

  // per-source pending terms, flags alone never dispatch
  assign t0_pend = timer0_ovf_flag & timer0_ovf_enable;
  assign i0_pend = ext_pin0_flag & ext_pin0_enable;
  assign rb_pend = port_change_flag & port_change_enable;
  assign i1_pend = ext_pin1_flag & ext_pin1_enable;
  assign i2_pend = ext_pin2_flag & ext_pin2_enable;
  assign pf_pend = pf_q & periph_enable & pf_mask;
  assign pf_any = |pf_pend;

  // split by priority bit; pin0 has none and is always high
  assign t0_hi = t0_pend & timer0_ovf_prio;
  assign t0_lo = t0_pend & ~timer0_ovf_prio;
  assign i0_hi = i0_pend;
  assign rb_hi = rb_pend & port_change_prio;
  assign rb_lo = rb_pend & ~port_change_prio;
  assign i1_hi = i1_pend & ext_pin1_prio;
  assign i1_lo = i1_pend & ~ext_pin1_prio;
  assign i2_hi = i2_pend & ext_pin2_prio;
  assign i2_lo = i2_pend & ~ext_pin2_prio;
  assign pf_hi = |(pf_pend & periph_prio);
  assign pf_lo = |(pf_pend & ~periph_prio);

  // any pending source at each level
  assign any_hi = i0_hi | t0_hi | rb_hi | i1_hi | i2_hi | pf_hi;
  assign any_lo = t0_lo | rb_lo | i1_lo | i2_lo | pf_lo;
  // compat mode: core sources need bit7, peripherals need bit6 too
  assign any_compat = t0_pend | i0_pend | rb_pend | i1_pend | i2_pend |
                      (pf_any & peripheral_or_low_enable);

  // hardware set vectors and acceptance
  assign accept = int_ack & int_req;
  assign main_hw_set = {5'h0, timer0_ovf, ev_pin0, mismatch};
  assign ext_hw_set = {6'h0, ev_pin2, ev_pin1};
  assign pf_wmask = `MASK_PF_RW & pf_mask;

  // dispatch decision and vector choice
  always @* begin
    req_d = 1'b0;
    vec_d = `VEC_HIGH;
    if (!priority_mode_enable) begin
      req_d = global_or_high_enable & any_compat;
    end else if (global_or_high_enable & any_hi) begin
      req_d = 1'b1;
    end else if (global_or_high_enable & peripheral_or_low_enable &
                 any_lo) begin
      // low priority also needs the high enable, which gates everything
      req_d = 1'b1;
      vec_d = `VEC_LOW;
    end
  end

  // main register next value
  always @* begin
    main_d = flag_upd(main_q, wdata, 8'hff, wr_main, main_hw_set);
    // acceptance clears the governing global enable
    if (accept) begin
      if (!priority_mode_enable || int_vector == `VEC_HIGH) begin
        main_d[`B_GIE] = 1'b0;
      end else begin
        main_d[`B_PEIE] = 1'b0;
      end
    end
  end

  // external pins and peripheral flag next values
  always @* begin
    ext_d = flag_upd(ext_q, wdata & `MASK_EXT, 8'hff, wr_ext,
                     ext_hw_set);
    pf_d = flag_upd(pf_q, wdata, pf_wmask, wr_pf, pf_ev);
    pf_d[`B_RXF] = rx_buffer_full;
    pf_d[`B_TXF] = tx_buffer_empty;
  end

  // register state
  always @(posedge clk) begin
    if (reset) begin
      main_q <= `RST_MAIN;
      edges_q <= `RST_EDGES;
      ext_q <= `RST_EXT;
      pf_q <= `RST_PFLAGS;
    end else begin
      main_q <= main_d;
      ext_q <= ext_d;
      pf_q <= pf_d;
      if (wr_edges) begin
        edges_q <= wdata & `MASK_EDGES;
      end
    end
  end

  // read port, data valid the cycle after the strobe only
  always @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      case (addr)
        `ADDR_MAIN: rdata <= main_q;
        `ADDR_EDGES: rdata <= edges_q & `MASK_EDGES;
        `ADDR_EXT: rdata <= ext_q & `MASK_EXT;
        `ADDR_PFLAGS: rdata <= pf_view;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // core request, vector and pull-up controls are registered
  always @(posedge clk) begin
    if (reset) begin
      int_req <= 1'b0;
      int_vector <= `VEC_HIGH;
      pullup_en <= 4'h0;
    end else begin
      // drop the request the cycle after acceptance
      int_req <= req_d & ~accept;
      int_vector <= vec_d;
      pullup_en <= pullup_disable ? 4'h0 : port_b_latch;
    end
  end

endmodule
`default_nettype wire
